// ===== verilog/secl_loader.sv
`timescale 1ns/1ps
//
// Contract
// - with the strap low the loader skips the memory and applies built-in values.
// - with the strap high the loader reads the memory after reset, once the strap has settled.
// - the memory is 1K bit of 16-bit words, one whole word per location.
// - device identifier comes from word 0x00, vendor identifier from 0x02.
// - class code 23..8 from word 0x08; class 7..0 and revision from word 0x0A.
// - header type comes from the low byte of word 0x0C.
// - subsystem identifier from word 0x2C, subsystem vendor from word 0x2E.
// - interrupt pin from high byte of 0x3E; latency and grant from word 0x3C.
// - gap A from low byte of 0x04, gap B from low byte of 0x10, mask from 0x04 high.
// - each serial port waits gap times one bit time between characters.
// - mask bits 8, 9 and 11 silence port A, port B and the parallel port.
// - the first byte received is the low byte of the word.
//
module secl_loader
   import secl_pkg::*;
#(
   parameter logic [15:0] DEF_DEVICE_ID  = 16'hA5C3,  // arbitrary value
   parameter logic [15:0] DEF_VENDOR_ID  = 16'h5A3C,  // arbitrary value
   parameter logic [7:0]  DEF_REVISION   = 8'h0E,     // arbitrary value
   parameter logic [15:0] DEF_SUBSYS_ID  = 16'h1357,  // arbitrary value
   parameter logic [15:0] DEF_SUBSYS_VEN = 16'h2468,  // arbitrary value
   parameter int          N_GAP_PORTS    = 2
)(
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       link_clk,
   input  wire logic       eeprom_use_strap,
   output logic            ee_cs,
   output logic            ee_sk,
   output logic            ee_di,
   input  wire logic       ee_do,
   input  wire logic [1:0] char_done,
   input  wire logic [1:0] bit_tick,
   output logic      [1:0] tx_hold,
   input  wire logic [2:0] irq_in,
   output logic      [2:0] irq_out,
   output secl_cfg_t       cfg,
   output logic            cfg_ready,
   output logic            cfg_retry
);

   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   if (N_GAP_PORTS != 2) begin : g_bad_ports
      $error("two serial ports carry a gap setting");
   end
   if (GAP_BITS != 8) begin : g_bad_gap
      $error("gap settings are one byte of a word");
   end
   if (EE_WORD_W != 16 || EE_ADDR_W != 6) begin : g_bad_word
      $error("loader serves 64 words of 16 bits only");
   end

   // ---------------------------------------------------------------
   // built-in configuration
   // ---------------------------------------------------------------
   localparam secl_cfg_t DEF_CFG = '{
      device_id:          DEF_DEVICE_ID,
      vendor_id:          DEF_VENDOR_ID,
      class_code:         DEF_CLASS_CODE,
      revision_id:        DEF_REVISION,
      header_type:        DEF_HEADER,
      subsys_id:          DEF_SUBSYS_ID,
      subsys_vendor_id:   DEF_SUBSYS_VEN,
      int_pin:            DEF_INT_PIN,
      max_lat:            DEF_MAX_LAT,
      min_gnt:            DEF_MIN_GNT,
      char_gap_setting_a: DEF_GAP,
      char_gap_setting_b: DEF_GAP,
      intr_mask:          DEF_MASK
   };

   // ---------------------------------------------------------------
   // word placement
   // ---------------------------------------------------------------
   function automatic secl_cfg_t place_word(secl_cfg_t c, logic [5:0] a, logic [15:0] w);
      secl_cfg_t r;
      r = c;
      case (a)
         ADDR_DEVICE_ID: r.device_id = w;
         ADDR_VENDOR_ID: r.vendor_id = w;
         ADDR_MASK_GAPA: begin
            r.intr_mask          = w[15:8];
            r.char_gap_setting_a = w[7:0];
         end
         ADDR_CLASS_HI:  r.class_code[23:8] = w;
         ADDR_CLASS_REV: begin
            r.class_code[7:0] = w[15:8];
            r.revision_id     = w[7:0];
         end
         ADDR_HEADER:    r.header_type = w[7:0];
         ADDR_GAPB:      r.char_gap_setting_b = w[7:0];
         ADDR_SUBSYS_ID: r.subsys_id = w;
         ADDR_SUBSYS_VN: r.subsys_vendor_id = w;
         ADDR_LAT_GNT: begin
            r.max_lat = w[15:8];
            r.min_gnt = w[7:0];
         end
         ADDR_INT_PIN:   r.int_pin = w[15:8];
         default: r = c;
      endcase
      return r;
   endfunction : place_word

   // ---------------------------------------------------------------
   // core sequencer
   // ---------------------------------------------------------------
   secl_core_t  st;
   secl_core_t  next_st;
   logic        ack_tgl;
   logic [15:0] ack_data;
   logic        ack_evt;
   logic [7:0]  gaps [N_GAP_PORTS];

   // data from the link is stable long before its toggle is seen here
   assign ack_evt = st.ack_sync[2] ^ st.ack_sync[1];

   always_comb begin
      next_st            = st;
      next_st.strap_sync = {st.strap_sync[0], eeprom_use_strap};
      next_st.ack_sync   = {st.ack_sync[1:0], ack_tgl};
      next_st.irq        = irq_in & ~{st.out.intr_mask[MASK_PARALLEL],
                                      st.out.intr_mask[MASK_UART_B],
                                      st.out.intr_mask[MASK_UART_A]};
      case (st.state)
         CS_START: begin
            next_st.settle = st.settle + 2'h1;
            // strap only trusted once the synchroniser has filled
            if (st.settle == STRAP_SETTLE) begin
               if (st.strap_sync[1]) begin
                  next_st.used_eeprom = 1'b1;
                  next_st.addr        = EE_FIRST_ADDR;
                  next_st.state       = CS_REQ;
               end else begin
                  next_st.out   = DEF_CFG;
                  next_st.ready = 1'b1;
                  next_st.state = CS_DONE;
               end
            end
         end
         CS_REQ: begin
            next_st.req_tgl = ~st.req_tgl;
            next_st.state   = CS_WAIT;
         end
         CS_WAIT: begin
            if (ack_evt) begin
               next_st.work = place_word(st.work, st.addr, ack_data);
               if (st.addr == EE_LAST_ADDR) begin
                  next_st.out   = next_st.work;
                  next_st.ready = 1'b1;
                  next_st.state = CS_DONE;
               end else begin
                  next_st.addr  = st.addr + 6'h01;
                  next_st.state = CS_REQ;
               end
            end
         end
         CS_DONE: next_st.state = CS_DONE;
         default: next_st.state = CS_START;
      endcase
      next_st.retry = ~next_st.ready;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st       <= '0;
         st.work  <= DEF_CFG;
         st.out   <= DEF_CFG;
         st.retry <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign cfg       = st.out;
   assign cfg_ready = st.ready;
   assign cfg_retry = st.retry;
   assign irq_out   = st.irq;

   // ---------------------------------------------------------------
   // serial memory link, on its own clock
   // ---------------------------------------------------------------
   secl_ee_link u_link (
      .link_clk (link_clk),
      .srst     (srst),
      .req_tgl  (st.req_tgl),
      .req_addr (st.addr),
      .ack_tgl  (ack_tgl),
      .ack_data (ack_data),
      .ee_cs    (ee_cs),
      .ee_sk    (ee_sk),
      .ee_di    (ee_di),
      .ee_do    (ee_do)
   );

   // ---------------------------------------------------------------
   // inter-character gap per serial port
   // ---------------------------------------------------------------
   assign gaps[0] = st.out.char_gap_setting_a;
   assign gaps[1] = st.out.char_gap_setting_b;

   for (genvar g = 0; g < N_GAP_PORTS; g++) begin : g_gap
      secl_gap_timer u_gap (
         .clk       (clk),
         .srst      (srst),
         .gap       (gaps[g]),
         .char_done (char_done[g]),
         .bit_tick  (bit_tick[g]),
         .tx_hold   (tx_hold[g])
      );
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   sequence store_s(logic [5:0] a);
      ack_evt && st.state == CS_WAIT && st.addr == a;
   endsequence

   sequence strap_seen_s(logic s);
      st.state == CS_START && st.settle == STRAP_SETTLE && st.strap_sync[1] == s;
   endsequence

   // start-up, presentation and address walk
   strap_skip_a: assert property (strap_seen_s(1'b0)
                                  |=> cfg_ready && !st.used_eeprom)
      else $error("memory not skipped");
   strap_default_a: assert property ($rose(cfg_ready) && !st.used_eeprom
                                     |-> cfg == DEF_CFG)
      else $error("defaults not applied");
   strap_read_a: assert property (strap_seen_s(1'b1)
                                  |=> st.state == CS_REQ && st.addr == EE_FIRST_ADDR)
      else $error("memory read not started");
   values_hidden_a: assert property (!cfg_ready |-> cfg == DEF_CFG && cfg_retry)
      else $error("values shown before load end");
   retry_match_a: assert property (cfg_retry == !cfg_ready)
      else $error("retry and ready disagree");
   ready_sticky_a: assert property (cfg_ready |=> cfg_ready && $stable(cfg))
      else $error("configuration changed after load");
   last_word_a: assert property ($rose(cfg_ready) && st.used_eeprom
                                 |-> $past(st.addr) == EE_LAST_ADDR)
      else $error("load ended before last word");
   addr_walk_a: assert property ($rose(st.state == CS_REQ) && st.addr != EE_FIRST_ADDR
                                 |-> st.addr == $past(st.addr) + 6'h01)
      else $error("word address skipped");

   // word placement into the working copy
   dev_store_a: assert property (store_s(ADDR_DEVICE_ID)
                                 |=> st.work.device_id == $past(ack_data))
      else $error("device identifier not stored");
   ids_store_a: assert property (store_s(ADDR_VENDOR_ID)
                                 |=> st.work.vendor_id == $past(ack_data))
      else $error("vendor identifier not stored");
   mask_store_a: assert property (store_s(ADDR_MASK_GAPA)
                                  |=> st.work.intr_mask == $past(ack_data[15:8])
                                   && st.work.char_gap_setting_a == $past(ack_data[7:0]))
      else $error("mask or gap a misplaced");
   class_store_a: assert property (store_s(ADDR_CLASS_HI)
                                   |=> st.work.class_code[23:8] == $past(ack_data))
      else $error("class code not stored");
   rev_store_a: assert property (store_s(ADDR_CLASS_REV)
                                 |=> st.work.revision_id == $past(ack_data[7:0])
                                  && st.work.class_code[7:0] == $past(ack_data[15:8]))
      else $error("revision or class byte misplaced");
   header_store_a: assert property (store_s(ADDR_HEADER)
                                    |=> st.work.header_type == $past(ack_data[7:0]))
      else $error("header type not stored");
   gap_store_a: assert property (store_s(ADDR_GAPB)
                                 |=> st.work.char_gap_setting_b == $past(ack_data[7:0]))
      else $error("gap b not stored");
   subsys_id_a: assert property (store_s(ADDR_SUBSYS_ID)
                                 |=> st.work.subsys_id == $past(ack_data))
      else $error("subsystem identifier not stored");
   subsys_store_a: assert property (store_s(ADDR_SUBSYS_VN)
                                    |=> st.work.subsys_vendor_id == $past(ack_data))
      else $error("subsystem vendor not stored");
   lat_store_a: assert property (store_s(ADDR_LAT_GNT)
                                 |=> st.work.max_lat == $past(ack_data[15:8])
                                  && st.work.min_gnt == $past(ack_data[7:0]))
      else $error("latency or grant misplaced");
   pin_store_a: assert property (store_s(ADDR_INT_PIN)
                                 |=> st.work.int_pin == $past(ack_data[15:8]))
      else $error("interrupt pin not stored");

   // interrupt masking, one cycle behind the inputs
   uart_a_mask_a: assert property (irq_out[0] |-> $past(irq_in[0])
                                   && !$past(st.out.intr_mask[MASK_UART_A]))
      else $error("masked port a interrupt passed");
   uart_b_mask_a: assert property (irq_out[1] |-> $past(irq_in[1])
                                   && !$past(st.out.intr_mask[MASK_UART_B]))
      else $error("masked port b interrupt passed");
   irq_mask_a: assert property (irq_out[2] |-> $past(irq_in[2])
                                && !$past(st.out.intr_mask[MASK_PARALLEL]))
      else $error("masked interrupt passed");

endmodule : secl_loader

// ===== inc/secl_pkg.sv
package secl_pkg;

   // ---------------------------------------------------------------
   // serial memory geometry and command
   // ---------------------------------------------------------------
   localparam int          EE_ADDR_W      = 6;
   localparam int          EE_WORD_W      = 16;
   localparam int          GAP_BITS       = 8;
   localparam logic [5:0]  EE_FIRST_ADDR  = 6'h00;
   localparam logic [5:0]  EE_LAST_ADDR   = 6'h3F;
   localparam logic [2:0]  READ_START_OP  = 3'h6;
   localparam logic [4:0]  LINK_LAST_BIT  = 5'h19;
   localparam logic [4:0]  DATA_FIRST_BIT = 5'h0A;
   localparam logic [1:0]  PH_SK_RISE     = 2'h1;
   localparam logic [1:0]  PH_SK_FALL     = 2'h3;
   localparam logic [1:0]  STRAP_SETTLE   = 2'h3;

   // ---------------------------------------------------------------
   // word locations
   // ---------------------------------------------------------------
   localparam logic [5:0]  ADDR_DEVICE_ID = 6'h00;
   localparam logic [5:0]  ADDR_VENDOR_ID = 6'h02;
   localparam logic [5:0]  ADDR_MASK_GAPA = 6'h04;
   localparam logic [5:0]  ADDR_CLASS_HI  = 6'h08;
   localparam logic [5:0]  ADDR_CLASS_REV = 6'h0A;
   localparam logic [5:0]  ADDR_HEADER    = 6'h0C;
   localparam logic [5:0]  ADDR_GAPB      = 6'h10;
   localparam logic [5:0]  ADDR_SUBSYS_ID = 6'h2C;
   localparam logic [5:0]  ADDR_SUBSYS_VN = 6'h2E;
   localparam logic [5:0]  ADDR_LAT_GNT   = 6'h3C;
   localparam logic [5:0]  ADDR_INT_PIN   = 6'h3E;

   // mask bit positions inside mask bits 15..8
   localparam int          MASK_UART_A    = 0;
   localparam int          MASK_UART_B    = 1;
   localparam int          MASK_PARALLEL  = 3;

   // ---------------------------------------------------------------
   // built-in values that carry no identity
   // ---------------------------------------------------------------
   localparam logic [23:0] DEF_CLASS_CODE = 24'h078000;
   localparam logic [7:0]  DEF_HEADER     = 8'h00;
   localparam logic [7:0]  DEF_INT_PIN    = 8'h01;
   localparam logic [7:0]  DEF_MAX_LAT    = 8'h00;
   localparam logic [7:0]  DEF_MIN_GNT    = 8'h00;
   localparam logic [7:0]  DEF_GAP        = 8'h00;
   localparam logic [7:0]  DEF_MASK       = 8'h00;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [15:0] device_id;
      logic [15:0] vendor_id;
      logic [23:0] class_code;
      logic [7:0]  revision_id;
      logic [7:0]  header_type;
      logic [15:0] subsys_id;
      logic [15:0] subsys_vendor_id;
      logic [7:0]  int_pin;
      logic [7:0]  max_lat;
      logic [7:0]  min_gnt;
      logic [7:0]  char_gap_setting_a;
      logic [7:0]  char_gap_setting_b;
      logic [7:0]  intr_mask;
   } secl_cfg_t;

   typedef enum logic [1:0] {
      CS_START = 2'h0, CS_REQ = 2'h1, CS_WAIT = 2'h3, CS_DONE = 2'h2
   } secl_core_st_t;

   typedef struct packed {
      secl_core_st_t state;
      logic [1:0]    settle;
      logic [1:0]    strap_sync;
      logic [2:0]    ack_sync;
      logic [5:0]    addr;
      logic          req_tgl;
      logic          used_eeprom;
      logic          ready;
      logic          retry;
      logic [2:0]    irq;
      secl_cfg_t     work;
      secl_cfg_t     out;
   } secl_core_t;

   typedef enum logic [1:0] {
      LS_IDLE = 2'h0, LS_SHIFT = 2'h1, LS_DONE = 2'h3
   } secl_link_st_t;

   typedef struct packed {
      secl_link_st_t state;
      logic [2:0]    req_sync;
      logic [1:0]    do_sync;
      logic [4:0]    bit_cnt;
      logic [1:0]    phase;
      logic [8:0]    cmd;
      logic [15:0]   shift;
      logic          cs;
      logic          sk;
      logic          di;
      logic          ack_tgl;
      logic [15:0]   data;
   } secl_link_t;

   typedef struct packed {
      logic [7:0] count;
      logic       hold;
   } secl_gap_t;

endpackage : secl_pkg

// ===== verilog/secl_gap_timer.sv
`timescale 1ns/1ps
module secl_gap_timer
   import secl_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic [7:0] gap,
   input  wire logic       char_done,
   input  wire logic       bit_tick,
   output logic            tx_hold
);
   secl_gap_t st;
   secl_gap_t next_st;

   // gap counted in whole bit times after each character
   always_comb begin
      next_st = st;
      if (char_done && gap != DEF_GAP) begin
         next_st.count = gap;
         next_st.hold  = 1'b1;
      end else if (st.hold && bit_tick) begin
         next_st.count = st.count - 8'h01;
         if (st.count == 8'h01) begin
            next_st.hold = 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tx_hold = st.hold;

   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   gap_start_a: assert property (char_done && gap != DEF_GAP
                                 |=> tx_hold && st.count == $past(gap))
      else $error("gap not started after character");
   gap_end_a: assert property ($fell(tx_hold)
                               |-> $past(bit_tick) && $past(st.count) == 8'h01)
      else $error("gap ended early");

endmodule : secl_gap_timer

// ===== verilog/secl_ee_link.sv
`timescale 1ns/1ps
module secl_ee_link
   import secl_pkg::*;
(
   input  wire logic        link_clk,
   input  wire logic        srst,
   input  wire logic        req_tgl,
   input  wire logic [5:0]  req_addr,
   output logic             ack_tgl,
   output logic [15:0]      ack_data,
   output logic             ee_cs,
   output logic             ee_sk,
   output logic             ee_di,
   input  wire logic        ee_do
);
   logic       rst_meta;
   logic       link_rst;
   logic       req_evt;
   secl_link_t st;
   secl_link_t next_st;

   // reset carried into the link domain
   always_ff @(posedge link_clk) begin
      rst_meta <= srst;
      link_rst <= rst_meta;
   end

   assign req_evt = st.req_sync[2] ^ st.req_sync[1];

   // one bit = four link clocks; sk high in phases 2 and 3
   always_comb begin
      next_st          = st;
      next_st.req_sync = {st.req_sync[1:0], req_tgl};
      next_st.do_sync  = {st.do_sync[0], ee_do};
      case (st.state)
         LS_IDLE: begin
            if (req_evt) begin
               next_st.cmd     = {READ_START_OP, req_addr};
               next_st.bit_cnt = '0;
               next_st.phase   = '0;
               next_st.cs      = 1'b1;
               next_st.di      = READ_START_OP[2];
               next_st.state   = LS_SHIFT;
            end
         end
         LS_SHIFT: begin
            next_st.phase = st.phase + 2'h1;
            // data appears after the sk rise; sampled once synchronised
            if (st.phase == PH_SK_RISE && st.bit_cnt >= DATA_FIRST_BIT) begin
               next_st.shift = {st.shift[14:0], st.do_sync[1]};
            end
            if (st.phase == PH_SK_RISE) begin
               next_st.sk = 1'b1;
            end
            if (st.phase == PH_SK_FALL) begin
               next_st.sk      = 1'b0;
               next_st.cmd     = {st.cmd[7:0], 1'b0};
               next_st.di      = st.cmd[7];
               next_st.bit_cnt = st.bit_cnt + 5'h01;
               if (st.bit_cnt == LINK_LAST_BIT) begin
                  next_st.cs    = 1'b0;
                  next_st.di    = 1'b0;
                  next_st.state = LS_DONE;
               end
            end
         end
         LS_DONE: begin
            next_st.data    = {st.shift[7:0], st.shift[15:8]};
            next_st.ack_tgl = ~st.ack_tgl;
            next_st.state   = LS_IDLE;
         end
         default: next_st.state = LS_IDLE;
      endcase
   end

   always_ff @(posedge link_clk) begin
      if (link_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign ack_tgl  = st.ack_tgl;
   assign ack_data = st.data;
   assign ee_cs    = st.cs;
   assign ee_sk    = st.sk;
   assign ee_di    = st.di;

   default clocking @(posedge link_clk); endclocking
   default disable iff (link_rst);

   sequence start_op_s;
      ee_di ##4 ee_di ##4 !ee_di;
   endsequence
   read_cmd_a: assert property ($rose(ee_cs) |-> start_op_s)
      else $error("read command not sent");
   word_frame_a: assert property ($rose(ee_cs) |-> ##103 ee_cs ##1 !ee_cs)
      else $error("word frame length wrong");

endmodule : secl_ee_link

// ===== verif/secl_ee_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// serial memory: 64 words of 16 bits, read command only
// ---------------------------------------------------------------
module secl_ee_model (
   input  wire logic ee_cs,
   input  wire logic ee_sk,
   input  wire logic ee_di,
   output logic      ee_do,
   output int        words,
   output logic      seq_err
);
   logic [7:0]  img [128];
   int          rises;
   logic [8:0]  cmd;
   logic [5:0]  exp_addr;
   logic [15:0] stream;

   initial begin
      ee_do    = 1'b0;
      words    = 0;
      seq_err  = 1'b0;
      rises    = 0;
      exp_addr = 6'h00;
      for (int i = 0; i < 128; i++) img[i] = 8'(i * 37);
   end

   always @(posedge ee_cs) rises = 0;
   // released line: never leave the last data bit standing
   always @(negedge ee_cs) ee_do <= ~ee_do;

   always @(posedge ee_sk) begin
      int idx;
      if (ee_cs) begin
         if (rises < 9) cmd = {cmd[7:0], ee_di};
         if (rises == 8) begin
            idx = 2 * int'(cmd[5:0]);
            if (cmd[8:6] !== 3'h6 || cmd[5:0] !== exp_addr) seq_err = 1'b1;
            stream = {img[idx], img[idx + 1]};
            ee_do <= 1'b0;
            exp_addr = exp_addr + 6'h01;
            words++;
         end else if (rises >= 9 && rises < 25) begin
            ee_do <= stream[24 - rises];
         end
         rises++;
      end
   end
endmodule : secl_ee_model

// ===== verif/secl_loader_test.sv
`timescale 1ns/1ps
module secl_loader_test;
   import secl_pkg::*;
   logic        clk, srst, link_clk, strap, ee_cs, ee_sk, ee_di, ee_do, cfg_ready, cfg_retry;
   logic [1:0]  char_done, bit_tick, tx_hold;
   logic [2:0]  irq_in, irq_out;
   secl_cfg_t   cfg;
   int          words, num_errors, num_checks;
   logic        seq_err;
   localparam secl_cfg_t DEF_CFG = '{16'hA5C3, 16'h5A3C, 24'h078000, 8'h0E, 8'h00, 16'h1357,
      16'h2468, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam secl_cfg_t LD_CFG = '{16'h1234, 16'h5678, 24'h9ABCDE, 8'hF0, 8'hA7, 16'h0F1E,
      16'h2D3C, 8'h03, 8'h4B, 8'h5A, 8'h03, 8'h02, 8'h09};
   logic [21:0] tab [11] = '{{6'h00, 16'h1234}, {6'h02, 16'h5678}, {6'h04, 16'h0903},
      {6'h08, 16'h9ABC}, {6'h0A, 16'hDEF0}, {6'h0C, 16'h11A7}, {6'h10, 16'h4402},
      {6'h2C, 16'h0F1E}, {6'h2E, 16'h2D3C}, {6'h3C, 16'h4B5A}, {6'h3E, 16'h0369}};

   secl_loader dut (.clk(clk), .srst(srst), .link_clk(link_clk), .eeprom_use_strap(strap),
      .ee_cs(ee_cs), .ee_sk(ee_sk), .ee_di(ee_di), .ee_do(ee_do), .char_done(char_done),
      .bit_tick(bit_tick), .tx_hold(tx_hold), .irq_in(irq_in), .irq_out(irq_out),
      .cfg(cfg), .cfg_ready(cfg_ready), .cfg_retry(cfg_retry));
   secl_ee_model ee (.ee_cs(ee_cs), .ee_sk(ee_sk), .ee_di(ee_di), .ee_do(ee_do),
      .words(words), .seq_err(seq_err));

   initial begin
      clk = 1'b0;
      link_clk = 1'b0;
      srst = 1'b1;
      strap = 1'b0;
      char_done = 2'h0;
      bit_tick = 2'h0;
      irq_in = 3'h0;
      num_errors = 0;
      num_checks = 0;
   end
   always #4 clk = ~clk;
   // odd start offset keeps the link clock out of step with clk
   initial #3 forever #16 link_clk = ~link_clk;

   task automatic check(string what, logic [159:0] exp, logic [159:0] got);
      num_checks++;
      if (exp !== got) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic do_reset(logic s);
      @(posedge clk);
      strap <= s;
      srst <= 1'b1;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
   endtask : do_reset

   task automatic irq_test(logic [2:0] exp);
      @(posedge clk);
      irq_in <= 3'h7;
      repeat (2) @(posedge clk);
      #1 check("irq_out", 160'(exp), 160'(irq_out));
      @(posedge clk);
      irq_in <= 3'h0;
   endtask : irq_test

   task automatic test_defaults();
      do_reset(1'b0);
      repeat (8) @(posedge clk);
      #1 check("ready", 160'(2'h2), 160'({cfg_ready, cfg_retry}));
      check("cfg default", 160'(DEF_CFG), 160'(cfg));
      check("words", 160'(0), 160'(words));
      irq_test(3'h7);
   endtask : test_defaults

   task automatic test_load();
      foreach (tab[i]) {ee.img[2 * tab[i][21:16]], ee.img[2 * tab[i][21:16] + 1]} =
         {tab[i][7:0], tab[i][15:8]};
      do_reset(1'b1);
      for (int i = 0; i < 40000 && words < 10; i++) @(posedge clk);
      #1 check("retry", 160'(2'h1), 160'({cfg_ready, cfg_retry}));
      check("cfg hidden", 160'(DEF_CFG), 160'(cfg));
      for (int i = 0; i < 40000 && cfg_ready !== 1'b1; i++) @(posedge clk);
      #1 check("cfg loaded", 160'(LD_CFG), 160'(cfg));
      check("words", 160'(64), 160'(words));
      check("sequence", 160'(0), 160'(seq_err));
      check("retry end", 160'(0), 160'(cfg_retry));
      irq_test(3'h2);
   endtask : test_load

   task automatic test_gap();
      @(posedge clk);
      char_done <= 2'h3;
      @(posedge clk);
      char_done <= 2'h0;
      #1 check("hold start", 160'(2'h3), 160'(tx_hold));
      // port a waits three bit times, port b two
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         bit_tick <= 2'h3;
         @(posedge clk);
         bit_tick <= 2'h0;
         #1 check("hold tick", 160'(k == 0 ? 2'h3 : k == 1 ? 2'h1 : 2'h0), 160'(tx_hold));
      end
      @(posedge clk);
      #1 check("hold end", 160'(2'h0), 160'(tx_hold));
   endtask : test_gap

   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : complete_run

   initial begin
      // a full load takes about 230 us; leave twice that
      #500000;
      num_errors++;
      complete_run();
   end

   initial begin
      test_defaults();
      test_load();
      test_gap();
      complete_run();
   end
endmodule : secl_loader_test
